// ==== hw/sbp_pkg.sv ====
/*
 * Package of the serial bus PHY register bank: register indices, field
 * positions, values after reset, fixed capability values and timing.
 * Assumes a 40 MHz system clock; Avalon word address equals register index.
 */
package sbp_pkg;

  localparam int REG_AW = 4;
  localparam int DATA_W = 32;

  // Register indices; Avalon byte address is four times the index
  localparam logic [3:0] IDX_NODE = 4'h0;
  localparam logic [3:0] IDX_GAP = 4'h1;
  localparam logic [3:0] IDX_PORTS = 4'h2;
  localparam logic [3:0] IDX_SPEED = 4'h3;
  localparam logic [3:0] IDX_LINK = 4'h4;
  localparam logic [3:0] IDX_EVENTS = 4'h5;
  localparam logic [3:0] IDX_RSVD6 = 4'h6;
  localparam logic [3:0] IDX_PAGE = 4'h7;

  // Field positions in the 8-bit value, counted from the LSB
  localparam int POS_ROOT_HOLDOFF = 7;
  localparam int POS_START_LBR = 6;
  localparam int POS_LINK_CTRL = 7;
  localparam int POS_CONTENDER = 6;
  localparam int POS_PAGE_SEL = 5;
  localparam int POS_PORT_SEL = 0;

  // Values after reset and fixed capability values
  localparam logic [5:0] GAP_RST = 6'h3F;
  localparam logic LINK_CTRL_RST = 1'b1;
  localparam logic [2:0] EXT_VAL = 3'h7;
  localparam logic [4:0] NUM_PORTS_VAL = 5'h02;
  localparam logic [2:0] SPEED_VAL = 3'h2;
  localparam logic [3:0] DELAY_VAL = 4'h0;
  localparam logic [2:0] JITTER_VAL = 3'h0;
  localparam logic [2:0] PAGE_RSV_LO = 3'h2;
  localparam logic [2:0] PAGE_RSV_HI = 3'h6;
  localparam logic [2:0] PAGE_TOP = 3'h7;
  localparam int PAGE_SLOTS = 3;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Long bus reset timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LBR_TIME_US = 166;
  localparam int LBR_CYCLES = (LBR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic pg_reserved(input logic [2:0] page);
    pg_reserved = (page >= PAGE_RSV_LO) && (page <= PAGE_RSV_HI);
  endfunction : pg_reserved

  // Storage slot of an implemented page: 0 and 1 keep theirs, 7 takes 2
  function automatic logic [1:0] pg_slot(input logic [2:0] page);
    pg_slot = (page == PAGE_TOP) ? 2'h2 : {1'b0, page[0]};
  endfunction : pg_slot

endpackage : sbp_pkg

// ==== hw/sbp_lbr_if.sv ====
/*
 * Interface between the register bank and its long bus reset timer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface sbp_lbr_if;
  logic start;
  logic active;
  logic done;
  modport ctl (output start, input active, input done);
  modport tmr (input start, output active, output done);
endinterface : sbp_lbr_if

// ==== hw/sbp_lbr_timer.sv ====
/*
 * Long bus reset timer: holds active for a fixed number of cycles after a
 * start pulse and pulses done at the end.
 * Assumes start is a one-cycle pulse from logic on clk_sys.
 */
`timescale 1ns/10ps
module sbp_lbr_timer
  import sbp_pkg::*;
#(
  parameter int CYCLES = LBR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  sbp_lbr_if.tmr lbr
);

  logic [15:0] cnt_r, cnt_nxt;
  logic active_r, active_nxt;
  logic done_r, done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    active_nxt = active_r;
    done_nxt = 1'b0;
    if (active_r) begin
      if (cnt_r == 16'h0000) begin
        active_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end else if (lbr.start) begin
      active_nxt = 1'b1;
      cnt_nxt = 16'(CYCLES - 1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
      active_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
      done_r <= done_nxt;
    end
  end

  assign lbr.active = active_r;
  assign lbr.done = done_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_lbr_runs;
    lbr.start && !active_r |=> active_r && (cnt_r == 16'(CYCLES - 1));
  endproperty
  a_lbr_runs: assert property (p_lbr_runs) else $error("long reset did not start");

endmodule : sbp_lbr_timer

// ==== hw/sbp_regs.sv ====
/*
 * Register bank of a two-port serial bus PHY: eight base registers, a
 * paged window of eight more, Avalon-MM slave with waitrequest, gap count
 * and bus reset control, root and link-active status.
 * Assumes one clock domain; pins are synchronised here; event inputs are
 * one-cycle pulses from logic on clk_sys.
 */
`timescale 1ns/10ps
module sbp_regs
  import sbp_pkg::*;
#(
  parameter int LBR_CYC = LBR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [REG_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [5:0] phy_id,
  input wire logic root_won,
  input wire logic bus_reset_evt,
  input wire logic cfg_gap_valid,
  input wire logic [5:0] cfg_gap_value,
  input wire logic xfer_busy,
  input wire logic cable_power_flag,
  input wire logic link_power_status_input,
  input wire logic contender_strap,
  output logic bus_reset_drive,
  output logic link_active_bit,
  output logic [5:0] gap_count,
  output logic root_holdoff_flag,
  output logic contender,
  output logic [7:0] feature_enables,
  output logic [2:0] power_class
);

  sbp_lbr_if lbr ();

  sbp_lbr_timer #(.CYCLES(LBR_CYC)) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .lbr(lbr)
  );

  // Pin synchronisers
  logic [2:0] s1_r, s2_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {cable_power_flag, link_power_status_input, contender_strap};
      s2_r <= s1_r;
    end
  end
  logic cps_s, lps_s, strap_s;
  assign {cps_s, lps_s, strap_s} = s2_r;

  // Bus handshake: answer one cycle after the request appears
  logic ack_r, ack_nxt, wreq_r, wreq_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic [7:0] rd_val;
  logic wr_take;

  // Control state
  logic rhb_r, rhb_nxt;
  logic lbr_req_r, lbr_req_nxt;
  logic [5:0] gap_r, gap_nxt;
  logic gap_upd_r, gap_upd_nxt;
  logic reset_seen_r, reset_seen_nxt;
  logic root_r, root_nxt;
  logic link_active_control_r, link_active_control_nxt;
  logic cont_r, cont_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [2:0] pwr_r, pwr_nxt;
  logic [7:0] evt_en_r, evt_en_nxt;
  logic [2:0] page_r, page_nxt;
  logic [3:0] port_r, port_nxt;
  logic link_act_r, link_act_nxt;
  logic lbr_start_r, lbr_start_nxt;
  logic [7:0] pmem_r [PAGE_SLOTS*8];
  logic [7:0] pmem_nxt [PAGE_SLOTS*8];
  logic bus_reset;
  logic [4:0] slot;

  assign wr_take = avs_write && ack_r && avs_byteenable[0];
  // A self-started long reset counts as a bus reset from its first cycle
  assign bus_reset = bus_reset_evt || lbr_start_r;
  assign slot = {pg_slot(page_r), avs_address[2:0]};

  // Read mux
  always_comb begin
    rd_val = 8'h00;
    if (!avs_address[3]) begin
      case (avs_address)
        IDX_NODE: rd_val = {phy_id, root_r, cps_s};
        IDX_GAP: rd_val = {rhb_r, lbr_req_r, gap_r};
        IDX_PORTS: rd_val = {EXT_VAL, NUM_PORTS_VAL};
        IDX_SPEED: rd_val = {SPEED_VAL, 1'b0, DELAY_VAL};
        IDX_LINK: rd_val = {link_active_control_r, cont_r, JITTER_VAL, pwr_r};
        IDX_EVENTS: rd_val = evt_en_r;
        IDX_PAGE: rd_val = {page_r, 1'b0, port_r};
        default: rd_val = 8'h00;
      endcase
    end else if (!pg_reserved(page_r)) begin
      rd_val = pmem_r[slot];
    end
  end

  always_comb begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    wreq_nxt = !ack_nxt;
    rdat_nxt = rdat_r;
    if ((avs_read || avs_write) && !ack_r) begin
      rdat_nxt = avs_read ? rd_val : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      wreq_r <= 1'b1;
      rdat_r <= 8'h00;
    end else begin
      ack_r <= ack_nxt;
      wreq_r <= wreq_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Register writes and hardware side effects
  always_comb begin
    rhb_nxt = rhb_r;
    lbr_req_nxt = lbr_req_r;
    gap_nxt = gap_r;
    gap_upd_nxt = gap_upd_r;
    reset_seen_nxt = reset_seen_r;
    root_nxt = root_r;
    link_active_control_nxt = link_active_control_r;
    cont_nxt = cont_r;
    strap_cnt_nxt = strap_cnt_r;
    pwr_nxt = pwr_r;
    evt_en_nxt = evt_en_r;
    page_nxt = page_r;
    port_nxt = port_r;
    pmem_nxt = pmem_r;
    // Strap caught once, after the synchroniser has filled
    if (strap_cnt_r != STRAP_WAIT) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT - 2'h1) begin
        cont_nxt = strap_s;
      end
    end
    // A gap write or config in the same cycle as a bus reset still counts
    if (bus_reset) begin
      root_nxt = 1'b0;
      if (reset_seen_r && !gap_upd_r) begin
        gap_nxt = GAP_RST;
      end
      reset_seen_nxt = 1'b1;
      gap_upd_nxt = 1'b0;
    end
    if (wr_take) begin
      case (avs_address)
        IDX_GAP: begin
          rhb_nxt = avs_writedata[POS_ROOT_HOLDOFF];
          lbr_req_nxt = avs_writedata[POS_START_LBR];
          gap_nxt = avs_writedata[5:0];
          gap_upd_nxt = 1'b1;
        end
        IDX_LINK: begin
          link_active_control_nxt = avs_writedata[POS_LINK_CTRL];
          cont_nxt = avs_writedata[POS_CONTENDER];
          pwr_nxt = avs_writedata[2:0];
        end
        IDX_EVENTS: evt_en_nxt = avs_writedata[7:0];
        IDX_PAGE: begin
          page_nxt = avs_writedata[POS_PAGE_SEL +: 3];
          port_nxt = avs_writedata[POS_PORT_SEL +: 4];
        end
        default: begin
          if (avs_address[3] && !pg_reserved(page_r)) begin
            pmem_nxt[slot] = avs_writedata[7:0];
          end
        end
      endcase
    end
    if (cfg_gap_valid) begin
      gap_nxt = cfg_gap_value;
      gap_upd_nxt = 1'b1;
    end
    // Becoming root beats a same-cycle reset; a reset beats a reset request
    if (root_won) root_nxt = 1'b1;
    if (bus_reset) lbr_req_nxt = 1'b0;
  end

  // Long reset waits for the current transfer to finish
  always_comb begin
    lbr_start_nxt = lbr_req_r && !xfer_busy && !lbr.active && !lbr_start_r;
    link_act_nxt = link_active_control_r && lps_s;
  end
  assign lbr.start = lbr_start_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rhb_r <= 1'b0;
      lbr_req_r <= 1'b0;
      gap_r <= GAP_RST;
      gap_upd_r <= 1'b0;
      reset_seen_r <= 1'b0;
      root_r <= 1'b0;
      link_active_control_r <= LINK_CTRL_RST;
      cont_r <= 1'b0;
      strap_cnt_r <= 2'h0;
      pwr_r <= 3'h0;
      evt_en_r <= 8'h00;
      page_r <= 3'h0;
      port_r <= 4'h0;
      link_act_r <= 1'b0;
      lbr_start_r <= 1'b0;
      for (int i = 0; i < PAGE_SLOTS * 8; i++) begin
        pmem_r[i] <= 8'h00;
      end
    end else begin
      rhb_r <= rhb_nxt;
      lbr_req_r <= lbr_req_nxt;
      gap_r <= gap_nxt;
      gap_upd_r <= gap_upd_nxt;
      reset_seen_r <= reset_seen_nxt;
      root_r <= root_nxt;
      link_active_control_r <= link_active_control_nxt;
      cont_r <= cont_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      pwr_r <= pwr_nxt;
      evt_en_r <= evt_en_nxt;
      page_r <= page_nxt;
      port_r <= port_nxt;
      link_act_r <= link_act_nxt;
      lbr_start_r <= lbr_start_nxt;
      pmem_r <= pmem_nxt;
    end
  end

  assign avs_readdata = {24'h000000, rdat_r};
  assign avs_waitrequest = wreq_r;
  assign bus_reset_drive = lbr.active;
  assign link_active_bit = link_act_r;
  assign gap_count = gap_r;
  assign root_holdoff_flag = rhb_r;
  assign contender = cont_r;
  assign feature_enables = evt_en_r;
  assign power_class = pwr_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_reset_twice;
    bus_reset && reset_seen_r && !gap_upd_r && !cfg_gap_valid
      && !(wr_take && avs_address == IDX_GAP);
  endsequence
  property p_gap_forced;
    s_reset_twice |=> gap_r == GAP_RST;
  endproperty
  a_gap_forced: assert property (p_gap_forced) else $error("gap count not forced");

  property p_ibr_clear;
    bus_reset |=> !lbr_req_r;
  endproperty
  a_ibr_clear: assert property (p_ibr_clear) else $error("reset bit survived bus reset");

  sequence s_lbr_asked;
    lbr_req_r && !xfer_busy && !lbr.active && !lbr_start_r;
  endsequence
  property p_lbr_go;
    s_lbr_asked |=> lbr_start_r ##1 bus_reset_drive;
  endproperty
  a_lbr_go: assert property (p_lbr_go) else $error("long reset not started");

  property p_lbr_hold;
    xfer_busy |=> !lbr_start_r;
  endproperty
  a_lbr_hold: assert property (p_lbr_hold) else $error("reset during transfer");

  property p_root_clear;
    bus_reset && !root_won |=> !root_r;
  endproperty
  a_root_clear: assert property (p_root_clear) else $error("root kept over bus reset");

  property p_root_set;
    root_won |=> root_r;
  endproperty
  a_root_set: assert property (p_root_set) else $error("root not set");

  property p_link_and;
    ##1 link_active_bit == ($past(link_active_control_r) && $past(lps_s));
  endproperty
  a_link_and: assert property (p_link_and) else $error("link bit mismatch");

  property p_rsvd_page;
    avs_read && !ack_r && avs_address[3] && pg_reserved(page_r) |=> avs_readdata == 32'h0;
  endproperty
  a_rsvd_page: assert property (p_rsvd_page) else $error("reserved page read nonzero");

  property p_rsvd_reg;
    avs_read && !ack_r && avs_address == IDX_RSVD6 |=> avs_readdata == 32'h0;
  endproperty
  a_rsvd_reg: assert property (p_rsvd_reg) else $error("reserved register nonzero");

  property p_ro_write;
    wr_take && avs_address == IDX_PORTS |=> $stable(gap_r) && $stable(evt_en_r) && $stable(page_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest timing");

endmodule : sbp_regs

// ==== sim/sbp_llc_model.sv ====
/*
 * Link controller model: Avalon-MM master doing single register accesses.
 * Assumes the register bank shares clk_sys and answers with waitrequest.
 */
`timescale 1ns/10ps
module sbp_llc_model
  import sbp_pkg::*;
(
  input wire logic clk_sys,
  output logic [REG_AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [DATA_W-1:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end

  // Answer taken at the rising edge where waitrequest is seen low
  task automatic xfer(input logic wr_en, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [DATA_W-1:0] q);
    @(posedge clk_sys);
    avs_read <= !wr_en;
    avs_write <= wr_en;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask : xfer

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
    logic [DATA_W-1:0] q;
    xfer(1'b1, a, d, be, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [DATA_W-1:0] q);
    xfer(1'b0, a, 8'h00, 4'hF, q);
  endtask : rd

  // Page chosen before any paged access
  task automatic sel_page(input logic [2:0] p);
    wr(IDX_PAGE, {p, 5'h00});
  endtask : sel_page
endmodule : sbp_llc_model

// ==== sim/serial_bus_phy_register_map_tb.sv ====
/*
 * Self-checking bench of the register bank, driving it through the link
 * controller model. Assumes a 40 MHz clock and a shortened long reset.
 */
`timescale 1ns/10ps
module serial_bus_phy_register_map_tb
  import sbp_pkg::*;
;
  localparam int LBR_SIM = 20;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [REG_AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [5:0] phy_id = 6'h2D;
  logic root_won = 1'b0;
  logic bus_reset_evt = 1'b0;
  logic cfg_gap_valid = 1'b0;
  logic [5:0] cfg_gap_value = 6'h00;
  logic xfer_busy = 1'b0;
  logic cable_power_flag = 1'b1;
  logic link_power_status_input = 1'b1;
  logic contender_strap = 1'b1;
  logic bus_reset_drive, link_active_bit, root_holdoff_flag, contender;
  logic [5:0] gap_count;
  logic [7:0] feature_enables;
  logic [2:0] power_class;
  logic [7:0] exp_base [8] = '{8'hB5, 8'h3F, 8'hE2, 8'h40, 8'hC0, 8'h00, 8'h00, 8'h00};
  int fails = 0;
  int checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  sbp_llc_model u_llc (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  sbp_regs #(.LBR_CYC(LBR_SIM)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phy_id(phy_id),
    .root_won(root_won), .bus_reset_evt(bus_reset_evt), .cfg_gap_valid(cfg_gap_valid),
    .cfg_gap_value(cfg_gap_value), .xfer_busy(xfer_busy), .cable_power_flag(cable_power_flag),
    .link_power_status_input(link_power_status_input), .contender_strap(contender_strap),
    .bus_reset_drive(bus_reset_drive), .link_active_bit(link_active_bit),
    .gap_count(gap_count), .root_holdoff_flag(root_holdoff_flag), .contender(contender),
    .feature_enables(feature_enables), .power_class(power_class));

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [DATA_W-1:0] q;
    u_llc.rd(a, q);
    chk(q, {24'h000000, exp});
  endtask : rchk

  task automatic bus_rst;
    @(posedge clk_sys);
    bus_reset_evt <= 1'b1;
    @(posedge clk_sys);
    bus_reset_evt <= 1'b0;
  endtask : bus_rst

  task automatic pulse_root;
    @(posedge clk_sys);
    root_won <= 1'b1;
    @(posedge clk_sys);
    root_won <= 1'b0;
  endtask : pulse_root

  task automatic t_base;
    for (int i = 0; i < 8; i++) rchk(4'(i), exp_base[i]);
    chk(32'(gap_count), 32'h3F);
  endtask : t_base

  // Read-only registers hammered with ones, then the whole base re-read
  task automatic t_ro;
    foreach (exp_base[i]) if (!(i inside {1, 4, 5, 7})) u_llc.wr(4'(i), 8'hFF);
    t_base();
  endtask : t_ro

  task automatic t_rw;
    u_llc.wr(IDX_EVENTS, 8'hA5);
    u_llc.wr(IDX_EVENTS, 8'h5A, 4'hE);
    rchk(IDX_EVENTS, 8'hA5);
    chk(32'(feature_enables), 32'hA5);
    u_llc.wr(IDX_LINK, 8'hBD);
    rchk(IDX_LINK, 8'h85);
    chk(32'({contender, power_class}), 32'h5);
    u_llc.wr(IDX_PAGE, 8'hFF);
    rchk(IDX_PAGE, 8'hEF);
  endtask : t_rw

  task automatic t_link;
    for (int k = 0; k < 4; k++) begin
      u_llc.wr(IDX_LINK, {k[1], 7'h40});
      link_power_status_input <= k[0];
      repeat (4) @(posedge clk_sys);
      chk(32'(link_active_bit), 32'(k[1] & k[0]));
    end
  endtask : t_link

  task automatic t_page;
    logic [2:0] pg [3] = '{3'h0, 3'h1, 3'h7};
    for (int i = 0; i < 3; i++) begin
      u_llc.sel_page(pg[i]);
      u_llc.wr(4'h8, 8'hA0 + 8'(i));
      u_llc.wr(4'hF, 8'hB0 + 8'(i));
    end
    // Page 2 could alias page 0 storage; checked below
    for (int p = 2; p < 7; p++) begin
      u_llc.sel_page(3'(p));
      u_llc.wr(4'h8, 8'h5A);
      rchk(4'h8, 8'h00);
      rchk(4'hF, 8'h00);
      rchk(IDX_PORTS, 8'hE2);
    end
    for (int i = 0; i < 3; i++) begin
      u_llc.sel_page(pg[i]);
      rchk(4'h8, 8'hA0 + 8'(i));
      rchk(4'hF, 8'hB0 + 8'(i));
    end
    rchk(IDX_PAGE, 8'hE0);
  endtask : t_page

  task automatic t_gap;
    u_llc.wr(IDX_GAP, 8'h95);
    @(negedge clk_sys);
    chk(32'({root_holdoff_flag, gap_count}), 32'h55);
    bus_rst();
    rchk(IDX_GAP, 8'h95);
    bus_rst();
    rchk(IDX_GAP, 8'hBF);
    u_llc.wr(IDX_GAP, 8'h10);
    bus_rst();
    rchk(IDX_GAP, 8'h10);
    @(posedge clk_sys);
    cfg_gap_valid <= 1'b1;
    cfg_gap_value <= 6'h22;
    @(posedge clk_sys);
    cfg_gap_valid <= 1'b0;
    bus_rst();
    rchk(IDX_GAP, 8'h22);
    bus_rst();
    rchk(IDX_GAP, 8'h3F);
  endtask : t_gap

  task automatic t_root;
    pulse_root();
    rchk(IDX_NODE, 8'hB7);
    bus_rst();
    rchk(IDX_NODE, 8'hB5);
    cable_power_flag <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rchk(IDX_NODE, 8'hB4);
    cable_power_flag <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : t_root

  task automatic t_lbr;
    int n;
    pulse_root();
    xfer_busy <= 1'b1;
    u_llc.wr(IDX_GAP, 8'h4A);
    repeat (10) @(posedge clk_sys);
    chk(32'(bus_reset_drive), 32'h0);
    rchk(IDX_GAP, 8'h4A);
    xfer_busy <= 1'b0;
    n = 0;
    while (bus_reset_drive !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while (bus_reset_drive === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(n), 32'(LBR_SIM));
    rchk(IDX_GAP, 8'h0A);
    rchk(IDX_NODE, 8'hB5);
  endtask : t_lbr

  task automatic t_hwrst;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_base();
  endtask : t_hwrst

  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_base();
    t_ro();
    t_rw();
    t_link();
    t_page();
    t_gap();
    t_root();
    t_lbr();
    t_hwrst();
    stop_test();
  end

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
endmodule : serial_bus_phy_register_map_tb
